/* hw/serial_port_pkg.sv */
// Constants, field layouts and state codes of the clock-synchronous serial port
package serial_port_pkg;

    // ********************************************************************
    // Register byte addresses on the Wishbone slave
    // ********************************************************************
    localparam logic [7:0] ADDR_CONTROL  = 8'h00;
    localparam logic [7:0] ADDR_BIT_RATE = 8'h04;
    localparam logic [7:0] ADDR_SHIFT    = 8'h08;
    localparam logic [7:0] ADDR_PROTECT  = 8'h0c;
    localparam logic [7:0] ADDR_STATUS   = 8'h10;

    // ********************************************************************
    // Field layouts and reset values
    // ********************************************************************
    // Control register, bit 7 down to bit 0
    typedef struct packed {
        logic       idle_output_level_bit;
        logic       internal_clock_select_bit;
        logic       msb_first_bit;
        logic       clock_polarity_bit;
        logic       pin_function_select_bit;
        logic       output_float_bit;
        logic [1:0] source_select;
    } serial_ctrl_t;

    localparam logic [7:0] CONTROL_RESET      = 8'h00;
    localparam logic [7:0] BIT_RATE_RESET     = 8'h00;
    localparam logic [7:0] SHIFT_RESET        = 8'h00;
    localparam int         PROTECT_RELEASE_POS = 2;
    localparam int         STATUS_BUSY_POS     = 0;
    localparam int         STATUS_HOLD_POS     = 1;
    localparam int         STATUS_RELEASE_POS  = 2;

    // ********************************************************************
    // Source clock selection and transfer length
    // ********************************************************************
    localparam logic [1:0] SRC_DIV1  = 2'h0;
    localparam logic [1:0] SRC_DIV8  = 2'h1;
    localparam logic [1:0] SRC_DIV32 = 2'h2;
    localparam logic [4:0] PRE_LAST_DIV1  = 5'h00;
    localparam logic [4:0] PRE_LAST_DIV8  = 5'h07;
    localparam logic [4:0] PRE_LAST_DIV32 = 5'h1f;
    localparam logic [2:0] LAST_BIT_INDEX = 3'h7;

    // Transfer states, Gray coded along idle, shift, hold
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_SHIFT = 2'b01,
        ST_HOLD  = 2'b11
    } xfer_state_t;

endpackage

/* hw/bit_rate_gen.sv */
// Bit rate generator: prescaled source clock divided by n+1, one tick per half period
`timescale 1ns/1ps
`default_nettype none

module bit_rate_gen (
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    input  wire logic       run,
    input  wire logic       restart,
    input  wire logic [1:0] source_select,
    input  wire logic [7:0] rate,
    output logic            tick
);

    logic [4:0] pre_cnt_reg;
    logic [4:0] pre_cnt_next;
    logic [7:0] rate_cnt_reg;
    logic [7:0] rate_cnt_next;
    logic       pre_term;
    logic       rate_term;

    // Terminal prescaler count for the chosen source; reserved code runs undivided
    function automatic logic [4:0] pre_last(input logic [1:0] sel);
        case (sel)
            serial_port_pkg::SRC_DIV8:  pre_last = serial_port_pkg::PRE_LAST_DIV8;
            serial_port_pkg::SRC_DIV32: pre_last = serial_port_pkg::PRE_LAST_DIV32;
            default:                    pre_last = serial_port_pkg::PRE_LAST_DIV1;
        endcase
    endfunction

    // ********************************************************************
    // Counter chain
    // ********************************************************************
    // Half period is src*(n+1), so a full clock period is 2(n+1) source cycles [R2]
    assign pre_term      = (pre_cnt_reg == pre_last(source_select));
    assign rate_term     = (rate_cnt_reg == rate);
    assign tick          = run & ~restart & pre_term & rate_term;
    assign pre_cnt_next  = (~run | restart | pre_term) ? 5'h00 : pre_cnt_reg + 5'h01;
    assign rate_cnt_next = (~run | restart) ? 8'h00 :
                           (pre_term & rate_term) ? 8'h00 :
                           pre_term ? rate_cnt_reg + 8'h01 : rate_cnt_reg;

    // Counters restart with every transfer so the first half period is whole
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pre_cnt_reg  <= 5'h00;
            rate_cnt_reg <= 8'h00;
        end else begin
            pre_cnt_reg  <= pre_cnt_next;
            rate_cnt_reg <= rate_cnt_next;
        end
    end

endmodule

`default_nettype wire

/* hw/clock_sync_serial_port.sv */
// Eight-bit clock-synchronous serial port with a classic Wishbone register slave
// Operation
// [R1] One transfer moves one byte: eight bits out, eight bits in.
// [R2] Internal clock is selected source divided by 2(n+1), n from bit rate register.
// [R3] Control bit cleared selects the external serial clock pin as transfer clock.
// [R4] Only a write to the shift register starts a transfer.
// [R5] Interrupt raised on the last sampling edge: rising at polarity 0, falling at 1.
// [R6] Bit order selectable: least significant or most significant bit first.
// [R7] Polarity bit chooses which clock edge drives and which samples data.
// [R8] External clock: idle data output held at the software-chosen level.
// [R9] Software must not write a new byte while a transfer runs.
// [R10] Internal clock: last bit held half a clock period, then output floats.
// [R11] A write during that hold floats the output at once.
// [R12] Internal clock stops after eight pulses, resting high at polarity 0, low at 1.
// [R13] External party must stop its clock after exactly eight pulses.
// [R14] External clock: write data or idle level only while clock rests at idle.
// [R15] Output float bit forces the data output pin to high impedance.
// [R16] Control register write allowed only right after setting the release bit.
// [R17] Bit rate and shift registers are written only while no transfer runs; the code accepts both writes at any time.
// [R18] Software sets the input pin as port input and selects the pin functions.
// [R19] Pins act as port, clock input or output, data output, float, data input.
// [R20] Received bits shift into the same register, which then holds the received byte.
//
// The Wishbone interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module clock_sync_serial_port (
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        serial_clock_pin_i,
    output logic             serial_clock_pin_o,
    output logic             serial_clock_pin_oe,
    output logic             serial_data_out_pin_o,
    output logic             serial_data_out_pin_oe,
    input  wire logic        serial_data_in_pin_i,
    output logic             pins_as_port,
    output logic             xfer_irq
);

    // ********************************************************************
    // Declarations
    // ********************************************************************
    serial_port_pkg::serial_ctrl_t ctrl_reg;
    serial_port_pkg::xfer_state_t  state_reg;
    serial_port_pkg::xfer_state_t  state_next;
    logic [7:0]  bit_rate_reg;
    logic [7:0]  shift_reg;
    logic [7:0]  shift_next;
    logic [2:0]  bit_cnt_reg;
    logic [2:0]  bit_cnt_next;
    logic        release_reg;
    logic        sclk_reg;
    logic        sclk_in_prev_reg;
    logic        dout_reg;
    logic        drive_on_reg;
    logic        ack_reg;
    logic [31:0] rdata_reg;
    logic        irq_reg;
    logic        bus_req;
    logic        wr_fire;
    logic        hit_control;
    logic        hit_bit_rate;
    logic        hit_shift;
    logic        hit_protect;
    logic        hit_status;
    logic        wr_control;
    logic        wr_bit_rate;
    logic        wr_shift;
    logic        wr_protect;
    logic [31:0] rdata_next;
    logic        use_internal;
    logic        idle_clk;
    logic        tick;
    logic        running;
    logic        int_drive;
    logic        int_sample;
    logic        ext_rise;
    logic        ext_fall;
    logic        ext_drive;
    logic        ext_sample;
    logic        drive_evt;
    logic        sample_evt;
    logic        last_sample;

    // Bit that goes out next, per chosen order
    function automatic logic next_out_bit(input logic [7:0] sr, input logic msb_first);
        next_out_bit = msb_first ? sr[7] : sr[0];
    endfunction

    // Address match on the word index, low byte-lane bits ignored
    function automatic logic addr_hit(input logic [7:0] adr, input logic [7:0] reg_adr);
        addr_hit = (adr[7:2] == reg_adr[7:2]);
    endfunction

    // ********************************************************************
    // Wishbone slave
    // ********************************************************************
    // Ack one cycle after the request; writes land on the ack edge
    assign bus_req      = wb_cyc_i & wb_stb_i;
    assign wr_fire      = bus_req & wb_we_i & ack_reg & wb_sel_i[0];
    assign hit_control  = addr_hit(wb_adr_i, serial_port_pkg::ADDR_CONTROL);
    assign hit_bit_rate = addr_hit(wb_adr_i, serial_port_pkg::ADDR_BIT_RATE);
    assign hit_shift    = addr_hit(wb_adr_i, serial_port_pkg::ADDR_SHIFT);
    assign hit_protect  = addr_hit(wb_adr_i, serial_port_pkg::ADDR_PROTECT);
    assign hit_status   = addr_hit(wb_adr_i, serial_port_pkg::ADDR_STATUS);
    assign wr_control   = wr_fire & hit_control & release_reg; // [R16]
    assign wr_bit_rate  = wr_fire & hit_bit_rate;
    assign wr_shift     = wr_fire & hit_shift; // [R4]
    assign wr_protect   = wr_fire & hit_protect;
    assign wb_ack_o     = ack_reg;
    assign wb_dat_o     = rdata_reg;

    // Read mux; unmapped addresses read zero and are still acknowledged
    assign rdata_next = hit_control  ? {24'h000000, ctrl_reg} :
                        hit_bit_rate ? {24'h000000, bit_rate_reg} :
                        hit_shift    ? {24'h000000, shift_reg} :
                        hit_protect  ? {29'h00000000, release_reg, 2'h0} :
                        hit_status   ? {29'h00000000, release_reg,
                                        state_reg == serial_port_pkg::ST_HOLD,
                                        state_reg == serial_port_pkg::ST_SHIFT} :
                        32'h00000000;

    // Bus handshake and read data capture
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ack_reg   <= 1'b0;
            rdata_reg <= 32'h00000000;
        end else begin
            ack_reg   <= bus_req & ~ack_reg;
            rdata_reg <= rdata_next;
        end
    end

    // Release bit lives for one further write only, like a single next instruction
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            release_reg <= 1'b0;
        end else if (wr_protect) begin
            release_reg <= wb_dat_i[serial_port_pkg::PROTECT_RELEASE_POS];
        end else if (wr_fire) begin
            release_reg <= 1'b0; // [R16]
        end
    end

    // Configuration registers
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_reg     <= serial_port_pkg::CONTROL_RESET;
            bit_rate_reg <= serial_port_pkg::BIT_RATE_RESET;
        end else begin
            if (wr_control) begin
                ctrl_reg <= wb_dat_i[7:0];
            end
            if (wr_bit_rate) begin
                bit_rate_reg <= wb_dat_i[7:0];
            end
        end
    end

    // ********************************************************************
    // Transfer clock sources
    // ********************************************************************
    assign use_internal = ctrl_reg.internal_clock_select_bit; // [R3]
    assign idle_clk     = ~ctrl_reg.clock_polarity_bit; // [R12]
    assign running      = use_internal & (state_reg != serial_port_pkg::ST_IDLE);

    bit_rate_gen u_rate (
        .core_clk      (core_clk),
        .sys_rst       (sys_rst),
        .run           (running),
        .restart       (wr_shift),
        .source_select (ctrl_reg.source_select),
        .rate          (bit_rate_reg),
        .tick          (tick)
    );

    // Leaving idle is the drive edge, returning to idle the sample edge [R7]
    assign int_drive  = tick & (state_reg == serial_port_pkg::ST_SHIFT) & (sclk_reg == idle_clk);
    assign int_sample = tick & (state_reg == serial_port_pkg::ST_SHIFT) & (sclk_reg != idle_clk);
    // Pin is synchronous to core_clk, so one register is enough for edges
    assign ext_rise   = serial_clock_pin_i & ~sclk_in_prev_reg;
    assign ext_fall   = ~serial_clock_pin_i & sclk_in_prev_reg;
    assign ext_drive  = ctrl_reg.clock_polarity_bit ? ext_rise : ext_fall; // [R7]
    assign ext_sample = ctrl_reg.clock_polarity_bit ? ext_fall : ext_rise; // [R7]
    // External edges keep shifting as long as pulses arrive
    assign drive_evt  = use_internal ? int_drive : ext_drive & ~wr_shift;
    assign sample_evt = use_internal ? int_sample : ext_sample & ~wr_shift;
    assign last_sample = sample_evt & (state_reg == serial_port_pkg::ST_SHIFT)
                         & (bit_cnt_reg == serial_port_pkg::LAST_BIT_INDEX);

    // Generated clock rests at idle; toggles only on generator ticks while shifting
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sclk_reg         <= 1'b1;
            sclk_in_prev_reg <= 1'b1; // Idle level at reset polarity, so no false edge
        end else begin
            sclk_in_prev_reg <= serial_clock_pin_i;
            if (int_drive | int_sample) begin
                sclk_reg <= ~sclk_reg; // [R2]
            end else if (state_reg != serial_port_pkg::ST_SHIFT) begin
                sclk_reg <= idle_clk; // [R12]
            end
        end
    end

    // ********************************************************************
    // Transfer sequencing
    // ********************************************************************
    // Hold only exists with the internal clock; eight samples end a transfer
    always_comb begin
        state_next   = state_reg;
        bit_cnt_next = bit_cnt_reg;
        case (state_reg)
            serial_port_pkg::ST_IDLE: begin
                if (wr_shift) begin
                    state_next   = serial_port_pkg::ST_SHIFT; // [R4]
                    bit_cnt_next = 3'h0;
                end
            end
            serial_port_pkg::ST_SHIFT: begin
                if (wr_shift) begin
                    bit_cnt_next = 3'h0;
                end else if (last_sample) begin
                    state_next   = use_internal ? serial_port_pkg::ST_HOLD
                                                : serial_port_pkg::ST_IDLE; // [R1] [R12]
                    bit_cnt_next = 3'h0;
                end else if (sample_evt) begin
                    bit_cnt_next = bit_cnt_reg + 3'h1;
                end
            end
            serial_port_pkg::ST_HOLD: begin
                if (wr_shift) begin
                    state_next   = serial_port_pkg::ST_SHIFT; // [R11]
                    bit_cnt_next = 3'h0;
                end else if (tick | ~use_internal) begin
                    state_next   = serial_port_pkg::ST_IDLE; // [R10]
                end
            end
            default: begin
                state_next   = serial_port_pkg::ST_IDLE;
                bit_cnt_next = 3'h0;
            end
        endcase
    end

    // Received bit enters at the far end while the outgoing bit leaves [R20]
    assign shift_next = wr_shift ? wb_dat_i[7:0] :
                        ~sample_evt ? shift_reg :
                        ctrl_reg.msb_first_bit ? {shift_reg[6:0], serial_data_in_pin_i}
                                               : {serial_data_in_pin_i, shift_reg[7:1]}; // [R6]

    // State, shifter and bit counter
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg   <= serial_port_pkg::ST_IDLE;
            bit_cnt_reg <= 3'h0;
            shift_reg   <= serial_port_pkg::SHIFT_RESET;
        end else begin
            state_reg   <= state_next;
            bit_cnt_reg <= bit_cnt_next;
            shift_reg   <= shift_next; // [R1]
        end
    end

    // Data output latch; a new write drops the drive at once, shortening the hold
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            dout_reg     <= 1'b0;
            drive_on_reg <= 1'b0;
        end else begin
            if (drive_evt) begin
                dout_reg <= next_out_bit(shift_reg, ctrl_reg.msb_first_bit); // [R6] [R7]
            end
            if (wr_shift) begin
                drive_on_reg <= 1'b0; // [R11]
            end else if (drive_evt & (state_reg == serial_port_pkg::ST_SHIFT)) begin
                drive_on_reg <= 1'b1;
            end else if (state_next == serial_port_pkg::ST_IDLE) begin
                drive_on_reg <= 1'b0; // [R10]
            end
        end
    end

    // Completion pulse follows the last sampling edge by one core cycle
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= last_sample & ~wr_shift; // [R5]
        end
    end

    // ********************************************************************
    // Pin functions
    // ********************************************************************
    // With the function bit clear every pin is left to the general port logic
    assign pins_as_port        = ~ctrl_reg.pin_function_select_bit; // [R19]
    assign serial_clock_pin_o  = sclk_reg;
    assign serial_clock_pin_oe = ctrl_reg.pin_function_select_bit & use_internal; // [R19]
    // External mode shows the idle level outside transfers [R8]
    assign serial_data_out_pin_o = (use_internal | (state_reg == serial_port_pkg::ST_SHIFT
                                   & drive_on_reg)) ? dout_reg
                                   : ctrl_reg.idle_output_level_bit; // [R8]
    // Float bit overrides any pin function [R15]
    assign serial_data_out_pin_oe = ctrl_reg.pin_function_select_bit
                                    & ~ctrl_reg.output_float_bit
                                    & (~use_internal | drive_on_reg); // [R10] [R15]
    assign xfer_irq = irq_reg;

    // ********************************************************************
    // Assertions
    // ********************************************************************
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_start;
        wr_shift ##1 (state_reg == serial_port_pkg::ST_SHIFT) && (bit_cnt_reg == 3'h0);
    endsequence

    sequence s_last_edge;
        last_sample && !wr_shift;
    endsequence

    a_write_starts: assert property (wr_shift |-> s_start) // [R4]
        else $error("shift write did not start a transfer");
    a_irq_last_edge: assert property (s_last_edge |=> xfer_irq) // [R5]
        else $error("no completion pulse after eighth sample");
    a_irq_cause: assert property (xfer_irq |-> $past(last_sample)) // [R1]
        else $error("completion pulse without eighth sample");
    a_clock_rests: assert property (use_internal && $past(state_reg) != serial_port_pkg::ST_SHIFT
        && state_reg != serial_port_pkg::ST_SHIFT && $stable(ctrl_reg)
        |-> serial_clock_pin_o == ~ctrl_reg.clock_polarity_bit) // [R12]
        else $error("internal clock not resting at idle level");
    a_float_wins: assert property (ctrl_reg.output_float_bit |-> !serial_data_out_pin_oe) // [R15]
        else $error("data output driven while float bit set");
    a_ext_idle_level: assert property (!use_internal && state_reg == serial_port_pkg::ST_IDLE
        |-> serial_data_out_pin_o == ctrl_reg.idle_output_level_bit) // [R8]
        else $error("external-clock idle level not shown");
    a_hold_ends: assert property (state_reg == serial_port_pkg::ST_HOLD && tick && !wr_shift
        |=> state_reg == serial_port_pkg::ST_IDLE && !drive_on_reg) // [R10]
        else $error("hold did not end on half period");
    a_hold_cut: assert property (state_reg == serial_port_pkg::ST_HOLD && wr_shift
        |=> !serial_data_out_pin_oe || !use_internal) // [R11]
        else $error("write during hold did not float output");
    a_protect_guard: assert property (wr_fire && hit_control && !release_reg
        |=> $stable(ctrl_reg)) // [R16]
        else $error("control changed without release");
    a_shift_in_lsb: assert property (sample_evt && !wr_shift && !ctrl_reg.msb_first_bit
        |=> shift_reg[7] == $past(serial_data_in_pin_i)) // [R20]
        else $error("received bit not shifted in");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

endmodule

`default_nettype wire

/* sim/serial_peer.sv */
// Behavioural model of the external clock-synchronous peer device
`timescale 1ns/1ps
`default_nettype none
// ********************************************************************
// Peer shifter
// ********************************************************************
module serial_peer (
    input  wire logic       core_clk,
    input  wire logic       sclk,
    input  wire logic       pol,
    input  wire logic       msb,
    input  wire logic       dout,
    input  wire logic       load,
    input  wire logic [7:0] tx_byte,
    output logic            din,
    output logic [7:0]      rx_byte
);
    logic       sclk_q;
    logic [7:0] tx_sr;
    wire        edge_seen  = sclk_q ^ sclk;
    wire        drive_edge = edge_seen & (sclk == pol);
    // Load shows the inverse of the first bit, so stale data never passes
    always_ff @(posedge core_clk) begin
        sclk_q <= sclk;
        if (load) begin
            tx_sr <= tx_byte;
            din   <= ~(msb ? tx_byte[7] : tx_byte[0]);
        end else if (drive_edge) begin
            din   <= msb ? tx_sr[7] : tx_sr[0];
            tx_sr <= msb ? {tx_sr[6:0], 1'b0} : {1'b0, tx_sr[7:1]};
        end
        if (edge_seen && sclk != pol)
            rx_byte <= msb ? {rx_byte[6:0], dout} : {dout, rx_byte[7:1]};
    end
endmodule
`default_nettype wire

/* sim/clock_sync_serial_port_tb.sv */
// Register-level testbench of the clock-synchronous serial port
`timescale 1ns/1ps
`default_nettype none
// ********************************************************************
// Bench
// ********************************************************************
module clock_sync_serial_port_tb;
    logic        core_clk, sys_rst, cyc, stb, we, ext_clk, load, pol, msb;
    logic [7:0]  adr, wdat, rd, peer_tx, peer_rx;
    logic [31:0] rdat;
    logic        ack, sclk_o, sclk_oe, dout, dout_oe, din, port, irq;
    int          num_errors, total_checks, cycles, irq_count, base, lat;
    wire         peer_sclk = sclk_oe ? sclk_o : ext_clk;
    clock_sync_serial_port dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
        .wb_dat_i({24'h000000, wdat}), .wb_dat_o(rdat), .wb_ack_o(ack),
        .serial_clock_pin_i(ext_clk), .serial_clock_pin_o(sclk_o), .serial_clock_pin_oe(sclk_oe),
        .serial_data_out_pin_o(dout), .serial_data_out_pin_oe(dout_oe),
        .serial_data_in_pin_i(din), .pins_as_port(port), .xfer_irq(irq));
    // A floating data output reads inverted, so sampling an undriven pin shows up
    serial_peer peer_u (.core_clk(core_clk), .sclk(peer_sclk), .pol(pol), .msb(msb),
        .dout(dout_oe ? dout : ~dout), .load(load), .tx_byte(peer_tx), .din(din),
        .rx_byte(peer_rx));
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    // Off-edge counting keeps the irq sample clear of the launching edge
    always @(negedge core_clk) begin
        cycles++;
        if (irq === 1'b1) irq_count++;
        if (cycles == 30000) begin
            num_errors++;
            end_of_test;
        end
    end
    task end_of_test;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input string nm, input logic [7:0] e, input logic [7:0] s);
        total_checks++;
        if (s !== e) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Classic single cycle; ack and read data taken at the same rising edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge core_clk);
        end while (ack !== 1'b1);
        rd = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge core_clk);
    endtask
    task set_ctrl(input logic [7:0] v);
        bus(1'b1, serial_port_pkg::ADDR_PROTECT, 8'h04);
        bus(1'b1, serial_port_pkg::ADDR_CONTROL, v);
    endtask
    // One byte each way; external clock pulses come from the bench itself
    task automatic xfer(input logic [7:0] c, input logic [7:0] n, input logic [7:0] t,
                        input logic [7:0] r, output int l);
        int k;
        pol <= c[4];
        msb <= c[5];
        set_ctrl(c);
        bus(1'b1, serial_port_pkg::ADDR_BIT_RATE, n);
        peer_tx <= r;
        load <= 1'b1;
        @(posedge core_clk);
        load <= 1'b0;
        irq_count = 0;
        bus(1'b1, serial_port_pkg::ADDR_SHIFT, t);
        // Rising edges from the write to the pulse; only differences are compared
        for (k = 0; k < 5000 && c[6] && irq !== 1'b1; k++) @(posedge core_clk);
        l = k;
        for (k = 0; k < 8 && !c[6]; k++) begin
            ext_clk <= 1'b0;
            repeat (4) @(posedge core_clk);
            ext_clk <= 1'b1;
            repeat (4) @(posedge core_clk);
        end
        repeat (40) @(posedge core_clk);
        chk("irq count", 8'h01, 8'(irq_count));
        chk("peer rx", t, peer_rx);
        bus(1'b0, serial_port_pkg::ADDR_SHIFT, 8'h00);
        chk("shift rx", r, rd);
        if (c[6]) chk("out float", 8'h00, {7'h00, dout_oe});
        if (c[6]) chk("clk rest", {7'h00, ~c[4]}, {7'h00, sclk_o});
        $display("test transfer ctrl %h done", c);
    endtask
    initial begin
        {sys_rst, load, ext_clk} = 3'h7;
        {cyc, stb, we, pol, msb} = 5'h00;
        {adr, wdat, peer_tx} = 24'h000000;
        {num_errors, total_checks, cycles} = 0;
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        load <= 1'b0;
        @(posedge core_clk);
        chk("port reset", 8'h01, {7'h00, port});
        bus(1'b1, serial_port_pkg::ADDR_CONTROL, 8'h48);
        bus(1'b0, serial_port_pkg::ADDR_CONTROL, 8'h00);
        chk("ctrl locked", serial_port_pkg::CONTROL_RESET, rd);
        $display("test reset done");
        xfer(8'h48, 8'h01, 8'h3a, 8'hc5, base);
        xfer(8'h78, 8'h03, 8'h96, 8'h5d, lat);
        chk("rate n3", 8'h20, 8'(lat - base));
        xfer(8'h69, 8'h00, 8'h81, 8'h7e, lat);
        chk("rate div8", 8'h60, 8'(lat - base));
        // Write again inside the half-period hold: output must float at once
        bus(1'b1, serial_port_pkg::ADDR_SHIFT, 8'h5a);
        while (irq !== 1'b1) @(posedge core_clk);
        bus(1'b1, serial_port_pkg::ADDR_SHIFT, 8'ha5);
        chk("hold cut", 8'h00, {7'h00, dout_oe});
        repeat (300) @(posedge core_clk);
        $display("test hold cut done");
        chk("port used", 8'h00, {7'h00, port});
        set_ctrl(8'h88);
        chk("idle level", 8'h03, {6'h00, dout, dout_oe});
        xfer(8'h88, 8'h00, 8'he4, 8'h2b, lat);
        set_ctrl(8'h8c);
        chk("float", 8'h00, {7'h00, dout_oe});
        $display("test pins done");
        end_of_test;
    end
endmodule
`default_nettype wire
